// ### lane_b_consts.vh
`ifndef LANE_B_CONSTS_VH
`define LANE_B_CONSTS_VH

// ************************************************************
// register offsets
// ************************************************************
`define OFS_RX_DETECT_CONTROL         8'h15
`define OFS_EQ_BOOST_CONTROL          8'h16
`define OFS_OUTPUT_PROTECTION_CONTROL 8'h17
`define OFS_OUTPUT_SWING_CONTROL      8'h18

// ************************************************************
// reset values
// ************************************************************
`define RST_RX_DETECT_CONTROL         8'h00
`define RST_EQ_BOOST_CONTROL          8'h2f
`define RST_OUTPUT_PROTECTION_CONTROL 8'hed
`define RST_OUTPUT_SWING_CONTROL      8'h82

// ************************************************************
// field positions and write masks
// ************************************************************
`define RX_DETECT_MODE_HI             3
`define RX_DETECT_MODE_LO             2
`define SHORT_PROT_BIT                7
`define SWING_ATT_HI                  2
`define SWING_ATT_LO                  0
`define WMASK_RX_DETECT_CONTROL       8'hff
`define WMASK_OUTPUT_SWING_CONTROL    8'h1f

// ************************************************************
// receiver detect mode codes
// ************************************************************
`define RX_DETECT_HIGH_Z              2'h0
`define RX_DETECT_AUTO_LIMITED        2'h1
`define RX_DETECT_AUTO_FOREVER        2'h2
`define RX_DETECT_TERM_50             2'h3

// ************************************************************
// timing
// ************************************************************
`define CLK_PERIOD_NS                 10
`define PROBE_INTERVAL_MS             12
`define PROBE_INTERVAL_CYCLES         ((`PROBE_INTERVAL_MS * 1000000) / `CLK_PERIOD_NS)
`define PROBE_LIMIT_MS                600
`define PROBE_ATTEMPTS                (`PROBE_LIMIT_MS / `PROBE_INTERVAL_MS)

`endif

// ### receiver_detect_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "lane_b_consts.vh"

module receiver_detect_sequencer #(
  parameter integer INTERVAL_CYCLES = `PROBE_INTERVAL_CYCLES,
  parameter integer MAX_ATTEMPTS    = `PROBE_ATTEMPTS
) (
  input  wire       ref_clk,
  input  wire       sys_rst,
  input  wire [1:0] receiver_detect_mode,
  input  wire       far_end_detected,
  output reg        probe_pulse,
  output reg        term_50_ohm,
  output reg        probing_stopped
);

  // ************************************************************
  // probe interval timer and attempt counter
  // ************************************************************
  reg [31:0] tick_r;
  reg [7:0]  attempts_r;
  reg        found_r;
  reg [1:0]  mode_r;
  wire       auto_mode = (receiver_detect_mode == `RX_DETECT_AUTO_LIMITED) ||
                         (receiver_detect_mode == `RX_DETECT_AUTO_FOREVER);
  wire       limit_hit = (receiver_detect_mode == `RX_DETECT_AUTO_LIMITED) &&
                         (attempts_r >= MAX_ATTEMPTS[7:0]);   // see RL2
  wire       tick_done = (tick_r == INTERVAL_CYCLES[31:0] - 32'h1);

  always @(posedge ref_clk) begin
    if (sys_rst || (receiver_detect_mode != mode_r)) begin
      tick_r          <= 32'h0;
      attempts_r      <= 8'h0;
      found_r         <= 1'b0;
      probe_pulse     <= 1'b0;
      probing_stopped <= 1'b0;
      mode_r          <= sys_rst ? 2'h0 : receiver_detect_mode;
    end else begin
      probe_pulse     <= 1'b0;
      probing_stopped <= auto_mode && !found_r && limit_hit;
      if (auto_mode && !found_r) begin
        if (far_end_detected) begin
          found_r <= 1'b1;                      // see RL4
        end else if (!limit_hit) begin
          if (tick_done) begin
            tick_r      <= 32'h0;
            probe_pulse <= 1'b1;                // see RL2 see RL3
            attempts_r  <= attempts_r + 8'h1;
          end else begin
            tick_r <= tick_r + 32'h1;
          end
        end
      end
    end
  end

  // ************************************************************
  // termination select
  // ************************************************************
  always @* begin
    case (receiver_detect_mode)
      `RX_DETECT_HIGH_Z:       term_50_ohm = 1'b0;    // see RL1
      `RX_DETECT_AUTO_LIMITED: term_50_ohm = found_r; // see RL4
      `RX_DETECT_AUTO_FOREVER: term_50_ohm = found_r; // see RL4
      `RX_DETECT_TERM_50:      term_50_ohm = 1'b1;    // see RL5
      default:             term_50_ohm = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ### lane_b_config_registers.v
`timescale 1ns/1ps
`default_nettype none
`include "lane_b_consts.vh"

// What this block does
// RL1: code 00 keeps input termination high-z
// RL2: code 01 probes every 12 ms, 50 tries
// RL3: code 10 probes every 12 ms until found
// RL4: auto codes high-z until detect, then 50 ohm
// RL5: code 11 applies 50 ohm at once
// RL6: register field used only with pin override
// RL7: master writes field only in PCIe sequence
// RL8: 0x15 holds mode bits 3:2, reset 0x00
// RL9: 0x16 boost control, reset 0x2f
// RL10: 0x17 bit 7 enables short protection
// RL11: master writes 0x17 low bits as 101
// RL12: 0x18 bits 2:0 select swing attenuation
// RL13: swing field resets to 010, register 0x82
// RL14: master should set swing 000 for PCIe
// RL15: fields read back and reset to defaults
module lane_b_config_registers #(
  parameter integer INTERVAL_CYCLES = `PROBE_INTERVAL_CYCLES,
  parameter integer MAX_ATTEMPTS    = `PROBE_ATTEMPTS
) (
  input  wire       ref_clk,
  input  wire       sys_rst,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr_en,
  input  wire [7:0] reg_wr_data,
  input  wire       reg_rd_en,
  output reg  [7:0] reg_rd_data,
  input  wire       pin_override,
  input  wire [1:0] pin_receiver_detect_mode,
  input  wire       far_end_detected,
  output wire       probe_pulse,
  output wire       term_50_ohm,
  output wire       probing_stopped,
  output wire [1:0] receiver_detect_mode,
  output wire [7:0] eq_boost,
  output wire       short_circuit_protect,
  output wire [2:0] output_swing_attenuation
);

  // ************************************************************
  // register storage
  // ************************************************************
  reg [7:0] rx_detect_control_r;
  reg [7:0] eq_boost_control_r;
  reg [7:0] output_protection_control_r;
  reg [7:0] output_swing_control_r;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_detect_control_r         <= `RST_RX_DETECT_CONTROL;         // see RL8 see RL15
      eq_boost_control_r          <= `RST_EQ_BOOST_CONTROL;          // see RL9 see RL15
      output_protection_control_r <= `RST_OUTPUT_PROTECTION_CONTROL; // see RL15
      output_swing_control_r      <= `RST_OUTPUT_SWING_CONTROL;      // see RL13 see RL15
    end else if (reg_wr_en) begin
      case (reg_addr)
        `OFS_RX_DETECT_CONTROL:         rx_detect_control_r <= reg_wr_data; // see RL8
        `OFS_EQ_BOOST_CONTROL:          eq_boost_control_r <= reg_wr_data;  // see RL9
        `OFS_OUTPUT_PROTECTION_CONTROL: output_protection_control_r <= reg_wr_data;
        `OFS_OUTPUT_SWING_CONTROL: begin
          // bits 7:5 are read-only and keep their reset value
          output_swing_control_r <= (output_swing_control_r & ~`WMASK_OUTPUT_SWING_CONTROL) |
                                    (reg_wr_data & `WMASK_OUTPUT_SWING_CONTROL); // see RL12
        end
        default: ;
      endcase
    end
  end

  // ************************************************************
  // read back
  // ************************************************************
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        `OFS_RX_DETECT_CONTROL:         reg_rd_data <= rx_detect_control_r; // see RL15
        `OFS_EQ_BOOST_CONTROL:          reg_rd_data <= eq_boost_control_r;
        `OFS_OUTPUT_PROTECTION_CONTROL: reg_rd_data <= output_protection_control_r;
        `OFS_OUTPUT_SWING_CONTROL:      reg_rd_data <= output_swing_control_r;
        default:                        reg_rd_data <= 8'h00;
      endcase
    end
  end

  // ************************************************************
  // field outputs
  // ************************************************************
  assign receiver_detect_mode = pin_override ?
                                rx_detect_control_r[`RX_DETECT_MODE_HI:`RX_DETECT_MODE_LO] :
                                pin_receiver_detect_mode;  // see RL6
  assign eq_boost                 = eq_boost_control_r;                              // see RL9
  assign short_circuit_protect    = output_protection_control_r[`SHORT_PROT_BIT];    // see RL10
  assign output_swing_attenuation = output_swing_control_r[`SWING_ATT_HI:`SWING_ATT_LO]; // see RL12

  // ************************************************************
  // receiver detect sequencing
  // ************************************************************
  receiver_detect_sequencer #(
    .INTERVAL_CYCLES (INTERVAL_CYCLES),
    .MAX_ATTEMPTS    (MAX_ATTEMPTS)
  ) u_seq (
    .ref_clk              (ref_clk),
    .sys_rst              (sys_rst),
    .receiver_detect_mode (receiver_detect_mode),
    .far_end_detected     (far_end_detected),
    .probe_pulse          (probe_pulse),
    .term_50_ohm          (term_50_ohm),
    .probing_stopped      (probing_stopped)
  );

endmodule
`default_nettype wire

// ### lane_b_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// checker
// ********
module lane_b_chk #(
  parameter integer INTERVAL_CYCLES = 4,
  parameter integer MAX_ATTEMPTS    = 3
) (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic       pin_override,
  input wire logic [1:0] pin_receiver_detect_mode,
  input wire logic       far_end_detected,
  input wire logic       probe_pulse,
  input wire logic       term_50_ohm,
  input wire logic       probing_stopped,
  input wire logic [1:0] receiver_detect_mode,
  input wire logic [7:0] eq_boost,
  input wire logic       short_circuit_protect,
  input wire logic [2:0] output_swing_attenuation
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire auto_m = receiver_detect_mode[1] ^ receiver_detect_mode[0];
  sequence wr_to(a);
    reg_wr_en && reg_addr == a;
  endsequence
  sequence quiet3;
    !probe_pulse [*3];
  endsequence
  AST_HIZ: assert property (receiver_detect_mode == 2'h0 |-> !term_50_ohm)
    else $error("termination not high-z in mode 0");
  AST_FIFTY: assert property (receiver_detect_mode == 2'h3 |-> term_50_ohm)
    else $error("termination not 50 ohm in mode 3");
  AST_FOUND: assert property (auto_m && far_end_detected && !probing_stopped
    ##1 $stable(receiver_detect_mode) |-> term_50_ohm) else $error("detect ignored");
  AST_GAP: assert property (probe_pulse |=> quiet3)
    else $error("probes too close");
  AST_QUIET: assert property ((!auto_m || $past(term_50_ohm) || $past(probing_stopped))
    && $stable(receiver_detect_mode) |-> !probe_pulse) else $error("stray probe");
  AST_MUX: assert property (!pin_override |-> receiver_detect_mode == pin_receiver_detect_mode)
    else $error("pin mode not used");
  AST_EQ: assert property (wr_to(8'h16) |=> eq_boost == $past(reg_wr_data))
    else $error("boost not written");
  AST_PROT: assert property (wr_to(8'h17) |=> short_circuit_protect == $past(reg_wr_data[7]))
    else $error("protect bit not written");
  AST_SWING: assert property (wr_to(8'h18) |=>
    output_swing_attenuation == $past(reg_wr_data[2:0])) else $error("swing not written");
  AST_RST: assert property ($past(sys_rst) |-> eq_boost == 8'h2f && short_circuit_protect
    && output_swing_attenuation == 3'h2) else $error("bad reset values");
endmodule
bind lane_b_config_registers lane_b_chk #(.INTERVAL_CYCLES(INTERVAL_CYCLES),
  .MAX_ATTEMPTS(MAX_ATTEMPTS)) chk_u (.ref_clk, .sys_rst, .reg_addr, .reg_wr_en, .reg_wr_data,
  .pin_override, .pin_receiver_detect_mode, .far_end_detected, .probe_pulse, .term_50_ohm,
  .probing_stopped, .receiver_detect_mode, .eq_boost, .short_circuit_protect,
  .output_swing_attenuation);
`default_nettype wire

// ### far_end_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// far-end receiver, answers after detect_after probes, never when 0
// ********
module far_end_model (
  input  wire logic       ref_clk,
  input  wire logic       clear,
  input  wire logic [3:0] detect_after,
  input  wire logic       probe_pulse,
  output wire logic       far_end_detected,
  output var  logic [7:0] probe_count
);
  always @(posedge ref_clk) begin
    if (clear)
      probe_count <= 8'h00;
    else if (probe_pulse)
      probe_count <= probe_count + 8'h01;
  end
  assign far_end_detected = detect_after != 4'h0 && probe_count >= {4'h0, detect_after};
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// bench
// ********
module tb_top;
  logic       ref_clk = 1'b0, sys_rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic       pin_override = 1'b0, clear = 1'b1, pend = 1'b0, was;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, v, expq[$];
  logic [1:0] pin_mode = 2'h0;
  logic [3:0] after = 4'h0;
  logic [15:0] tbl [5] = '{16'h0000, 16'hc200, 16'h4103, 16'h9605, 16'h4a02};
  wire  [7:0] reg_rd_data, eq_boost, probe_count;
  wire  [1:0] mode;
  wire  [2:0] swing;
  wire        pulse, term, stopped, far, prot;
  int         mismatches = 0, checked = 0, cyc = 0;
  lane_b_config_registers #(.INTERVAL_CYCLES(4), .MAX_ATTEMPTS(3)) dut_u (.ref_clk, .sys_rst,
    .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .pin_override,
    .pin_receiver_detect_mode(pin_mode), .far_end_detected(far), .probe_pulse(pulse),
    .term_50_ohm(term), .probing_stopped(stopped), .receiver_detect_mode(mode), .eq_boost,
    .short_circuit_protect(prot), .output_swing_attenuation(swing));
  far_end_model fm_u (.ref_clk, .clear, .detect_after(after), .probe_pulse(pulse),
    .far_end_detected(far), .probe_count);
  always #5 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    expq.push_back(e);
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
  endtask
  always @(posedge ref_clk) begin
    was = reg_rd_en;
    #1;
    if (pend) chk(reg_rd_data, expq.pop_front());
    pend = was;
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    v = $urandom(51);
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    clear = 1'b0;
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h2f);
    rd(8'h17, 8'hed);
    rd(8'h18, 8'h82);
    rd(8'h14, 8'h00);
    $display("reset test done");
    repeat (4) begin
      v = $urandom();
      wr(8'h16, v);
      rd(8'h16, v);
      wr(8'h17, {v[7], 7'h05});
      chk({7'h0, prot}, {7'h0, v[7]});
      wr(8'h18, {v[7:5], 2'h0, v[2:0]});
      rd(8'h18, {3'h4, 2'h0, v[2:0]});
      wr(8'h15, {4'h0, v[3:2], 2'h0});
      rd(8'h15, {4'h0, v[3:2], 2'h0});
      wr(8'h14, v);
      rd(8'h14, 8'h00);
    end
    wr(8'h18, 8'h00);
    chk({5'h0, swing}, 8'h00);
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    rd(8'h16, 8'h2f);
    $display("register test done");
    pin_override = 1'b1;
    for (int i = 0; i < 5; i++) begin
      clear = 1'b1;
      after = tbl[i][13:10];
      wr(8'h15, {4'h0, tbl[i][15:14], 2'h0});
      clear = 1'b0;
      repeat (40) @(negedge ref_clk);
      chk({6'h0, mode}, {6'h0, tbl[i][15:14]});
      chk({7'h0, term}, {7'h0, tbl[i][9]});
      chk({7'h0, stopped}, {7'h0, tbl[i][8]});
      chk(probe_count, tbl[i][7:0]);
    end
    pin_override = 1'b0;
    pin_mode = 2'h3;
    repeat (2) @(negedge ref_clk);
    chk({5'h0, mode, term}, 8'h07);
    $display("detect test done");
    test_done();
  end
endmodule
`default_nettype wire
